// ==== pisv_irq_map.sv ====
/*
 pisv_irq_map: input stage and vector mapping of the peripheral interrupt unit.
 samples 70 grouped active-low request lines, keeps per-source request flags,
 resolves the fixed hardware order among equal priority levels and latches the
 winner's vector slot. assumes request lines are synchronous to core_clk_i and
 that priority levels and the accept strobe come from the priority/mask logic.
*/
// Operation
// RULE1 - edge sources set flag on falling edge
// RULE2 - level sources pend while line low
// RULE3 - software writes ignored for level sources
// RULE4 - 22 sources, each own vector slot
// RULE5 - analog converter0 one edge input
// RULE6 - serial ch0/1 transmit edge requests
// RULE7 - serial ch0/1 receive edge requests
// RULE8 - serial ch2/3 level, two inputs
// RULE9 - debug unit one edge request
// RULE10 - transfer engine two level groups, five
// RULE11 - can channel0 level, nineteen inputs combined
// RULE12 - timer output group5 single edge
// RULE13 - other timer output groups level combined
// RULE14 - timer input groups level combined
// RULE15 - timer inputs at 0x94 to 0xa0
// RULE16 - timer outputs at 0xa8 to 0xc4
// RULE17 - transfer, serial slots 0xc8 to 0xd8
// RULE18 - remaining slots 0xdc to 0x10c
// RULE19 - accept latches low 16 vector bits
// RULE20 - equal levels resolved by fixed order
// RULE21 - vector read clears edge flags only
// RULE22 - register lines before edge detection
`timescale 1ns/10ps
module pisv_irq_map #(
   parameter int NSRC = pisv_pkg::NUM_SRC
) (
   // clock and reset
   input  wire logic                                core_clk_i,
   input  wire logic                                nrst_i,
   // peripheral request lines
   input  wire pisv_pkg::pisv_lines_t               lines_n_i,
   // software access to request flags
   input  wire pisv_pkg::pisv_flag_wr_t             flag_wr_i,
   // priority levels, 3 bits per source
   input  wire logic [NSRC*pisv_pkg::LVL_W-1:0]     priority_level_i,
   // acceptance and vector register read
   input  wire logic                                accept_i,
   input  wire logic                                vector_rd_i,
   // results
   output logic      [NSRC-1:0]                     request_flag_o,
   output logic                                     sel_valid_o,
   output logic      [pisv_pkg::IDX_W-1:0]          sel_idx_o,
   output logic      [pisv_pkg::LVL_W-1:0]          sel_level_o,
   output logic      [pisv_pkg::VEC_W-1:0]          vector_register_o
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic any_low(input logic [31:0] v, input int n);
      logic r;
      r = 1'b0;
      for (int i = 0; i < n; i++)
         r = r | ~v[i];
      return r;
   endfunction

   // ---------------------------------------------------------------
   // line combining, one active-high request per source
   // ---------------------------------------------------------------
   pisv_pkg::pisv_lines_t l;
   assign l = lines_n_i;

   wire logic [NSRC-1:0] req_raw;
   assign req_raw[pisv_pkg::S_TIN4]   = any_low(32'(l.timer_in_4_n), pisv_pkg::TIN4_N); // RULE14
   assign req_raw[pisv_pkg::S_TIMER_IN_3]   = any_low(32'(l.timer_in_3_n), pisv_pkg::TIMER_IN_3_N); // RULE14
   assign req_raw[pisv_pkg::S_TIN2]   = any_low(32'(l.timer_in_2_n), pisv_pkg::TIN2_N); // RULE14
   assign req_raw[pisv_pkg::S_TIN1]   = any_low(32'(l.timer_in_1_n), pisv_pkg::TIN1_N); // RULE14
   assign req_raw[pisv_pkg::S_TOUT7]  = any_low(32'(l.timer_out_7_n), pisv_pkg::TOUT7_N); // RULE13
   assign req_raw[pisv_pkg::S_TOUT6]  = any_low(32'(l.timer_out_6_n), pisv_pkg::TOUT6_N); // RULE13
   assign req_raw[pisv_pkg::S_TOUT5]  = ~l.timer_out_5_n[0]; // RULE12
   assign req_raw[pisv_pkg::S_TOUT4]  = any_low(32'(l.timer_out_4_n), pisv_pkg::TOUT4_N); // RULE13
   assign req_raw[pisv_pkg::S_TOUT3]  = any_low(32'(l.timer_out_3_n), pisv_pkg::TOUT3_N); // RULE13
   assign req_raw[pisv_pkg::S_TOUT2]  = any_low(32'(l.timer_out_2_n), pisv_pkg::TOUT2_N); // RULE13
   assign req_raw[pisv_pkg::S_TOUT1]  = any_low(32'(l.timer_out_1_n), pisv_pkg::TOUT1_N); // RULE13
   assign req_raw[pisv_pkg::S_TOUT0]  = any_low(32'(l.timer_out_0_n), pisv_pkg::TOUT0_N); // RULE13
   assign req_raw[pisv_pkg::S_XFER04] = any_low(32'(l.xfer_0_4_n), pisv_pkg::XFER_N); // RULE10
   assign req_raw[pisv_pkg::S_S1RX]   = ~l.serial_ch1_rx_n; // RULE7
   assign req_raw[pisv_pkg::S_S1TX]   = ~l.serial_ch1_tx_n; // RULE6
   assign req_raw[pisv_pkg::S_S0RX]   = ~l.serial_ch0_rx_n; // RULE7
   assign req_raw[pisv_pkg::S_S0TX]   = ~l.serial_ch0_tx_n; // RULE6
   assign req_raw[pisv_pkg::S_ADC0]   = ~l.analog_converter0_n; // RULE5
   assign req_raw[pisv_pkg::S_XFER59] = any_low(32'(l.xfer_5_9_n), pisv_pkg::XFER_N); // RULE10
   assign req_raw[pisv_pkg::S_SER23]  = any_low(32'(l.serial_ch2_3_n), pisv_pkg::SER23_N); // RULE8
   assign req_raw[pisv_pkg::S_RTD]    = ~l.realtime_debug_unit_n; // RULE9
   assign req_raw[pisv_pkg::S_CAN_CHANNEL0]   = any_low(32'(l.can_channel0_n), pisv_pkg::CAN_N); // RULE11

   // ---------------------------------------------------------------
   // sampled request level and its previous value
   // ---------------------------------------------------------------
   logic [NSRC-1:0] req_ff;
   logic [NSRC-1:0] req_d_ff;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_ff   <= '0;
         req_d_ff <= '0;
      end else begin
         req_ff   <= req_raw; // RULE22
         req_d_ff <= req_ff; // RULE22
      end
   end

   wire logic [NSRC-1:0] fall_evt;
   assign fall_evt = req_ff & ~req_d_ff; // RULE1

   // ---------------------------------------------------------------
   // source currently latched in the vector register
   // ---------------------------------------------------------------
   logic                        held_valid_ff;
   logic [pisv_pkg::IDX_W-1:0]  held_idx_ff;

   // ---------------------------------------------------------------
   // per-source request flags
   // ---------------------------------------------------------------
   logic [NSRC-1:0] flag_ff;
   logic [NSRC-1:0] nxt_flag;

   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_src
         if (pisv_pkg::EDGE_MASK[g]) begin : g_edge
            wire logic sw_hit;
            wire logic rd_clr;
            assign sw_hit = flag_wr_i.en && (int'(flag_wr_i.idx) == g);
            // software clear and vector-read clear win over a same-cycle set
            assign rd_clr = vector_rd_i && held_valid_ff && (int'(held_idx_ff) == g); // RULE21
            assign nxt_flag[g] = sw_hit ? flag_wr_i.value :
                                 rd_clr ? 1'b0 :
                                 (flag_ff[g] | fall_evt[g]); // RULE1
         end else begin : g_level
            assign nxt_flag[g] = req_ff[g]; // RULE2 RULE3
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i)
         flag_ff <= pisv_pkg::FLAG_RESET;
      else
         flag_ff <= nxt_flag;
   end

   // ---------------------------------------------------------------
   // resolution: lowest level wins, ties to the lower index
   // ---------------------------------------------------------------
   logic                       win_valid;
   logic [pisv_pkg::IDX_W-1:0] win_idx;
   logic [pisv_pkg::LVL_W-1:0] win_lvl;

   always_comb begin
      logic [pisv_pkg::LVL_W-1:0] lv;
      lv        = '0;
      win_valid = 1'b0;
      win_idx   = '0;
      win_lvl   = '1;
      // scan from lowest priority upward so non-strict compare hands ties to the lower index
      for (int i = NSRC - 1; i >= 0; i--) begin
         lv = priority_level_i[i*pisv_pkg::LVL_W +: pisv_pkg::LVL_W];
         if (flag_ff[i] && (lv != 3'h7) && (!win_valid || lv <= win_lvl)) begin // RULE20
            win_valid = 1'b1;
            win_idx   = pisv_pkg::IDX_W'(i);
            win_lvl   = lv;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel_valid_o <= 1'b0;
         sel_idx_o   <= '0;
         sel_level_o <= '1;
      end else begin
         sel_valid_o <= win_valid;
         sel_idx_o   <= win_idx;
         sel_level_o <= win_lvl;
      end
   end

   // ---------------------------------------------------------------
   // acceptance: latch source and its vector slot
   // ---------------------------------------------------------------
   wire logic take;
   assign take = accept_i && sel_valid_o;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         held_valid_ff <= 1'b0;
         held_idx_ff   <= '0;
      end else if (take) begin
         held_valid_ff <= 1'b1;
         held_idx_ff   <= sel_idx_o;
      end else if (vector_rd_i) begin
         held_valid_ff <= 1'b0;
      end
   end

   pisv_vec_rom #(
      .DEPTH (NSRC),
      .W     (pisv_pkg::VEC_W)
   ) u_rom (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .rd_en_i    (take), // RULE19 RULE4 RULE15 RULE16 RULE17 RULE18
      .rd_idx_i   (sel_idx_o),
      .rd_data_o  (vector_register_o)
   );

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i)
         request_flag_o <= pisv_pkg::FLAG_RESET;
      else
         request_flag_o <= nxt_flag;
   end

endmodule

// ==== pisv_pkg.sv ====
/*
 peripheral interrupt source and vector map package: source indices, edge/level
 classes, vector slot addresses, input group widths and shared types.
 assumes nothing of its surroundings beyond a sv-2012 compiler.
*/
package pisv_pkg;

   // ---------------------------------------------------------------
   // source count and widths
   // ---------------------------------------------------------------
   localparam int NUM_SRC   = 22;
   localparam int VEC_W     = 16;
   localparam int LVL_W     = 3;
   localparam int IDX_W     = 5;

   // ---------------------------------------------------------------
   // input line counts per source group
   // ---------------------------------------------------------------
   localparam int TIN4_N    = 1;
   localparam int TIMER_IN_3_N    = 4;
   localparam int TIN2_N    = 4;
   localparam int TIN1_N    = 1;
   localparam int TOUT7_N   = 2;
   localparam int TOUT6_N   = 2;
   localparam int TOUT5_N   = 1;
   localparam int TOUT4_N   = 4;
   localparam int TOUT3_N   = 2;
   localparam int TOUT2_N   = 6;
   localparam int TOUT1_N   = 2;
   localparam int TOUT0_N   = 4;
   localparam int XFER_N    = 5;
   localparam int SER23_N   = 2;
   localparam int CAN_N     = 19;

   // ---------------------------------------------------------------
   // source indices in fixed priority order, 0 is highest
   // ---------------------------------------------------------------
   localparam logic [IDX_W-1:0] S_TIN4   = 5'h00;
   localparam logic [IDX_W-1:0] S_TIMER_IN_3   = 5'h01;
   localparam logic [IDX_W-1:0] S_TIN2   = 5'h02;
   localparam logic [IDX_W-1:0] S_TIN1   = 5'h03;
   localparam logic [IDX_W-1:0] S_TOUT7  = 5'h04;
   localparam logic [IDX_W-1:0] S_TOUT6  = 5'h05;
   localparam logic [IDX_W-1:0] S_TOUT5  = 5'h06;
   localparam logic [IDX_W-1:0] S_TOUT4  = 5'h07;
   localparam logic [IDX_W-1:0] S_TOUT3  = 5'h08;
   localparam logic [IDX_W-1:0] S_TOUT2  = 5'h09;
   localparam logic [IDX_W-1:0] S_TOUT1  = 5'h0a;
   localparam logic [IDX_W-1:0] S_TOUT0  = 5'h0b;
   localparam logic [IDX_W-1:0] S_XFER04 = 5'h0c;
   localparam logic [IDX_W-1:0] S_S1RX   = 5'h0d;
   localparam logic [IDX_W-1:0] S_S1TX   = 5'h0e;
   localparam logic [IDX_W-1:0] S_S0RX   = 5'h0f;
   localparam logic [IDX_W-1:0] S_S0TX   = 5'h10;
   localparam logic [IDX_W-1:0] S_ADC0   = 5'h11;
   localparam logic [IDX_W-1:0] S_XFER59 = 5'h12;
   localparam logic [IDX_W-1:0] S_SER23  = 5'h13;
   localparam logic [IDX_W-1:0] S_RTD    = 5'h14;
   localparam logic [IDX_W-1:0] S_CAN_CHANNEL0   = 5'h15;

   // ---------------------------------------------------------------
   // edge class mask, bit set means falling-edge recognized
   // ---------------------------------------------------------------
   localparam logic [NUM_SRC-1:0] EDGE_MASK = 22'h13e040;

   // ---------------------------------------------------------------
   // vector slot addresses (low 16 bits), indexed by source
   // ---------------------------------------------------------------
   localparam logic [NUM_SRC*VEC_W-1:0] VEC_TABLE = {
      16'h010c, 16'h00f0, 16'h00ec, 16'h00e8, 16'h00dc, 16'h00d8,
      16'h00d4, 16'h00d0, 16'h00cc, 16'h00c8, 16'h00c4, 16'h00c0,
      16'h00bc, 16'h00b8, 16'h00b4, 16'h00b0, 16'h00ac, 16'h00a8,
      16'h00a0, 16'h009c, 16'h0098, 16'h0094};

   localparam logic [VEC_W-1:0]   VEC_RESET = 16'h0000;
   localparam logic [NUM_SRC-1:0] FLAG_RESET = 22'h000000;

   // ---------------------------------------------------------------
   // grouped peripheral request lines, all active low
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [TIN4_N-1:0]  timer_in_4_n;
      logic [TIMER_IN_3_N-1:0]  timer_in_3_n;
      logic [TIN2_N-1:0]  timer_in_2_n;
      logic [TIN1_N-1:0]  timer_in_1_n;
      logic [TOUT7_N-1:0] timer_out_7_n;
      logic [TOUT6_N-1:0] timer_out_6_n;
      logic [TOUT5_N-1:0] timer_out_5_n;
      logic [TOUT4_N-1:0] timer_out_4_n;
      logic [TOUT3_N-1:0] timer_out_3_n;
      logic [TOUT2_N-1:0] timer_out_2_n;
      logic [TOUT1_N-1:0] timer_out_1_n;
      logic [TOUT0_N-1:0] timer_out_0_n;
      logic [XFER_N-1:0]  xfer_0_4_n;
      logic               serial_ch1_rx_n;
      logic               serial_ch1_tx_n;
      logic               serial_ch0_rx_n;
      logic               serial_ch0_tx_n;
      logic               analog_converter0_n;
      logic [XFER_N-1:0]  xfer_5_9_n;
      logic [SER23_N-1:0] serial_ch2_3_n;
      logic               realtime_debug_unit_n;
      logic [CAN_N-1:0]   can_channel0_n;
   } pisv_lines_t;

   // ---------------------------------------------------------------
   // software write to a request flag
   // ---------------------------------------------------------------
   typedef struct packed {
      logic               en;
      logic [IDX_W-1:0]   idx;
      logic               value;
   } pisv_flag_wr_t;

endpackage

// ==== pisv_vec_rom.sv ====
/*
 pisv_vec_rom: constant vector slot table, registered read data.
 assumes the index is below the source count; others read as zero.
*/
`timescale 1ns/10ps
module pisv_vec_rom #(
   parameter int DEPTH = pisv_pkg::NUM_SRC,
   parameter int W     = pisv_pkg::VEC_W
) (
   // clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     nrst_i,
   // read port
   input  wire logic                     rd_en_i,
   input  wire logic [pisv_pkg::IDX_W-1:0] rd_idx_i,
   output logic      [W-1:0]             rd_data_o
);

   wire logic [W-1:0] word;
   assign word = (int'(rd_idx_i) < DEPTH) ?
                 pisv_pkg::VEC_TABLE[rd_idx_i*W +: W] : '0;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i)
         rd_data_o <= pisv_pkg::VEC_RESET;
      else if (rd_en_i)
         rd_data_o <= word;
   end

endmodule

// ==== pisv_periph_model.sv ====
/*
 pisv_periph_model: peripherals that raise active-low request lines.
 assumes the bench drives act_i on the rising edge of core_clk_i.
*/
`timescale 1ns/10ps
module pisv_periph_model (
   // clock and reset
   input  wire logic                                     core_clk_i,
   input  wire logic                                     nrst_i,
   // per-line cause from the bench, 1 means active
   input  wire logic [$bits(pisv_pkg::pisv_lines_t)-1:0] act_i,
   // request lines toward the interrupt unit
   output pisv_pkg::pisv_lines_t                         lines_n_o
);
   // a line stays low for as long as its cause is active
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lines_n_o <= '1;
      end else begin
         lines_n_o <= pisv_pkg::pisv_lines_t'(~act_i);
      end
   end
endmodule

// ==== pisv_irq_map_chk.sv ====
/*
 pisv_irq_map_chk: port-level checks for pisv_irq_map.
 assumes one clock domain; bound by name at the foot of this file.
*/
`timescale 1ns/10ps
module pisv_irq_map_chk #(
   parameter int NSRC = pisv_pkg::NUM_SRC
) (
   // clock, reset and inputs
   input wire logic                            core_clk_i,
   input wire logic                            nrst_i,
   input wire pisv_pkg::pisv_lines_t           lines_n_i,
   input wire pisv_pkg::pisv_flag_wr_t         flag_wr_i,
   input wire logic [NSRC*pisv_pkg::LVL_W-1:0] priority_level_i,
   input wire logic                            accept_i,
   input wire logic                            vector_rd_i,
   // outputs under watch
   input wire logic [NSRC-1:0]                 request_flag_o,
   input wire logic                            sel_valid_o,
   input wire logic [pisv_pkg::IDX_W-1:0]      sel_idx_o,
   input wire logic [pisv_pkg::LVL_W-1:0]      sel_level_o,
   input wire logic [pisv_pkg::VEC_W-1:0]      vector_register_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_lvl_set; !lines_n_i.timer_in_4_n[0] [*2] |=> request_flag_o[0]; endproperty
   a_lvl_set: assert property (p_lvl_set) else $error("level flag not set");
   property p_lvl_clr; lines_n_i.timer_in_4_n[0] [*2] |=> !request_flag_o[0]; endproperty
   a_lvl_clr: assert property (p_lvl_clr) else $error("level flag not following line");
   property p_edge_set;
      $fell(lines_n_i.analog_converter0_n) ##1 !(vector_rd_i || flag_wr_i.en)
         |=> request_flag_o[17];
   endproperty
   a_edge_set: assert property (p_edge_set) else $error("edge flag not set");
   property p_edge_once;
      $rose(request_flag_o[17]) |-> $past(flag_wr_i.en) ||
         ($past(lines_n_i.analog_converter0_n, 3) && !$past(lines_n_i.analog_converter0_n, 2));
   endproperty
   a_edge_once: assert property (p_edge_once) else $error("edge flag without edge");
   property p_vec_can;
      accept_i && sel_valid_o && sel_idx_o == 5'h15 |=> vector_register_o == 16'h010c;
   endproperty
   a_vec_can: assert property (p_vec_can) else $error("wrong last slot");
   property p_vec_hold; !(accept_i && sel_valid_o) |=> $stable(vector_register_o); endproperty
   a_vec_hold: assert property (p_vec_hold) else $error("vector changed unaccepted");
   property p_rd_clear;
      vector_rd_i && !flag_wr_i.en && vector_register_o == 16'h00dc |=> !request_flag_o[17];
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("edge flag kept on read");
   property p_rd_keep;
      vector_rd_i && !$past(lines_n_i.timer_in_4_n[0]) |=> request_flag_o[0];
   endproperty
   a_rd_keep: assert property (p_rd_keep) else $error("level flag cleared by read");
   property p_sel_none; request_flag_o == '0 |=> !sel_valid_o; endproperty
   a_sel_none: assert property (p_sel_none) else $error("selection with no flag");
   c_accept: cover property (accept_i && sel_valid_o);
   c_rd_edge: cover property (vector_rd_i && vector_register_o == 16'h00dc);
   c_tie: cover property (sel_valid_o && $countones(request_flag_o) > 1);
endmodule

bind pisv_irq_map pisv_irq_map_chk #(.NSRC(NSRC)) u_pisv_irq_map_chk (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .lines_n_i(lines_n_i), .flag_wr_i(flag_wr_i),
   .priority_level_i(priority_level_i), .accept_i(accept_i), .vector_rd_i(vector_rd_i),
   .request_flag_o(request_flag_o), .sel_valid_o(sel_valid_o), .sel_idx_o(sel_idx_o),
   .sel_level_o(sel_level_o), .vector_register_o(vector_register_o));

// ==== test_peripheral_irq_source_vector_map.sv ====
/*
 test_peripheral_irq_source_vector_map: directed bench for pisv_irq_map.
 assumes the peripheral model and the checker are compiled alongside.
*/
`timescale 1ns/10ps
module test_peripheral_irq_source_vector_map;
   localparam int NS = pisv_pkg::NUM_SRC;
   localparam int NL = $bits(pisv_pkg::pisv_lines_t);
   localparam logic [NS-1:0] EDGE = 22'h13e040;
   localparam logic [NS-1:0] ONE  = 22'h000001;
   logic                    core_clk_i;
   logic                    nrst_i;
   logic [NL-1:0]           act;
   pisv_pkg::pisv_lines_t   lines_n;
   pisv_pkg::pisv_flag_wr_t flag_wr_i;
   logic [NS*3-1:0]         prio;
   logic                    accept_i;
   logic                    vector_rd_i;
   logic [NS-1:0]           flags;
   logic                    sel_v;
   logic [4:0]              sel_i;
   logic [2:0]              sel_l;
   logic [15:0]             vec;
   int                      n_errors = 0;
   int                      compares = 0;
   int                      cycles = 0;
   int gw[NS] = '{1, 4, 4, 1, 2, 2, 1, 4, 2, 6, 2, 4, 5, 1, 1, 1, 1, 1, 5, 2, 1, 19};

   pisv_periph_model u_pisv_periph_model (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .act_i(act), .lines_n_o(lines_n));
   pisv_irq_map u_pisv_irq_map (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .lines_n_i(lines_n),
      .flag_wr_i(flag_wr_i), .priority_level_i(prio), .accept_i(accept_i),
      .vector_rd_i(vector_rd_i), .request_flag_o(flags), .sel_valid_o(sel_v),
      .sel_idx_o(sel_i), .sel_level_o(sel_l), .vector_register_o(vec));

   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 4000) begin
         fail("timeout");
         close_out();
      end
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic fail(input string m);
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic chk_flags(input logic [NS-1:0] e);
      compares++;
      if (flags !== e) fail($sformatf("flags %h want %h", flags, e));
   endtask
   task automatic chk_sel(input logic v, input logic [4:0] i, input logic [2:0] l);
      compares++;
      if ({sel_v, sel_i, sel_l} !== {v, i, l})
         fail($sformatf("sel %b %h %h", sel_v, sel_i, sel_l));
   endtask
   task automatic chk_vec(input logic [15:0] e);
      compares++;
      if (vec !== e) fail($sformatf("vector %h want %h", vec, e));
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic set_line(input int s, input int m, input logic v);
      int pos;
      pos = NL;
      @(posedge core_clk_i);
      for (int k = 0; k <= s; k++) pos -= gw[k];
      act[pos + m] <= v;
   endtask
   task automatic strobe(input logic rd);
      @(posedge core_clk_i);
      accept_i <= !rd;
      vector_rd_i <= rd;
      @(posedge core_clk_i);
      accept_i <= 1'b0;
      vector_rd_i <= 1'b0;
      #1;
   endtask
   task automatic sw_write(input int i, input logic v);
      @(posedge core_clk_i);
      flag_wr_i <= '{en: 1'b1, idx: 5'(i), value: v};
      @(posedge core_clk_i);
      flag_wr_i.en <= 1'b0;
      #1;
   endtask
   function automatic logic [15:0] slot(input int s);
      if (s < 4) return 16'h0094 + 16'(4 * s);
      if (s < 18) return 16'h00a8 + 16'(4 * (s - 4));
      if (s == 18) return 16'h00e8;
      if (s == 19) return 16'h00ec;
      if (s == 20) return 16'h00f0;
      return 16'h010c;
   endfunction
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic sweep();
      for (int s = 0; s < NS; s++) begin
         set_line(s, s % gw[s], 1'b1);
         settle(3);
         chk_flags(ONE << s);
         settle(1);
         chk_sel(1'b1, 5'(s), 3'h0);
         strobe(1'b0);
         chk_vec(slot(s));
         if (EDGE[s]) begin
            set_line(s, s % gw[s], 1'b0);
            settle(3);
            chk_flags(ONE << s);
            strobe(1'b1);
            chk_flags('0);
         end else begin
            strobe(1'b1);
            chk_flags(ONE << s);
            set_line(s, s % gw[s], 1'b0);
            settle(3);
            chk_flags('0);
         end
      end
   endtask
   task automatic tie();
      set_line(1, 0, 1'b1);
      prio[3 +: 3] <= 3'h3;
      prio[63 +: 3] <= 3'h3;
      set_line(21, 0, 1'b1);
      settle(4);
      chk_sel(1'b1, 5'h01, 3'h3);
      @(posedge core_clk_i);
      prio[63 +: 3] <= 3'h2;
      settle(2);
      chk_sel(1'b1, 5'h15, 3'h2);
      @(posedge core_clk_i);
      prio[63 +: 3] <= 3'h7;
      settle(2);
      chk_sel(1'b1, 5'h01, 3'h3);
      set_line(1, 0, 1'b0);
      prio <= '0;
      set_line(21, 0, 1'b0);
      settle(4);
      chk_flags('0);
   endtask
   task automatic sw();
      sw_write(0, 1'b1);
      settle(1);
      chk_flags('0);
      set_line(19, 1, 1'b1);
      settle(3);
      sw_write(19, 1'b0);
      chk_flags(ONE << 19);
      set_line(19, 1, 1'b0);
      sw_write(20, 1'b1);
      settle(2);
      chk_flags(ONE << 20);
      sw_write(20, 1'b0);
      set_line(17, 0, 1'b1);
      settle(3);
      chk_flags(ONE << 17);
      sw_write(17, 1'b0);
      settle(4);
      chk_flags('0);
      set_line(17, 0, 1'b0);
      set_line(17, 0, 1'b1);
      settle(3);
      chk_flags(ONE << 17);
   endtask
   task automatic close_out();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      nrst_i = 1'b0;
      act = '0;
      flag_wr_i = '0;
      prio = '0;
      accept_i = 1'b0;
      vector_rd_i = 1'b0;
      repeat (8) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      settle(1);
      chk_flags('0);
      chk_sel(1'b0, 5'h00, 3'h7);
      chk_vec(16'h0000);
      sweep();
      tie();
      sw();
      close_out();
   end
endmodule
